// File: core/core_status_irq_power_regs.sv
// Core status word, extended interrupt enable/priority and power control
// Behaviour
// RULE1: Carry set on add carry or subtract borrow
// RULE2: Aux carry set on nibble carry or borrow
// RULE3: Two user flags hold software values only
// RULE4: Bank select picks one of four banks
// RULE5: Software avoids bank write then register move
// RULE6: Overflow set on signed add/subtract overflow
// RULE7: Multiply sets overflow when product exceeds 255
// RULE8: Divide by zero sets overflow
// RULE9: Otherwise those instructions clear overflow
// RULE10: Parity shows odd ones count of accumulator
// RULE11: Comparator edge enables gate edge flag requests
// RULE12: Window enable gates ADC window requests
// RULE13: Clock valid priority bit selects high level
// RULE14: Bits five to two prioritise soft interrupts
// RULE15: End of conversion priority bit selects level
// RULE16: Only reset ends stop; restart at zero
// RULE17: Missing clock timeout resets out of stop
// RULE18: Software shuts analog peripherals before stop
// RULE19: Baud doubler doubles serial port rate
// RULE20: Stop write powers down, reads zero
// RULE21: Idle write gates processor clock, reads zero
// RULE22: High priority pending source served first
`include "core_status_regs_params.svh"

module core_status_irq_power_regs #(
    parameter int unsigned MCD_COUNT = `MCD_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Special-function bus
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic [7:0] sfrWdata,
    input wire logic sfrRead,
    output logic [7:0] sfrRdata,
    // Arithmetic result from execution unit
    input wire logic aluValid,
    input wire core_status_pkg::alu_op_t aluOp,
    input wire logic [7:0] aluOpA,
    input wire logic [7:0] aluOpB,
    input wire logic [7:0] accumulator,
    // Interrupt sources
    input wire logic cmp1_rise_flag,
    input wire logic cmp1_fall_flag,
    input wire logic cmp0_rise_flag,
    input wire logic cmp0_fall_flag,
    input wire logic adcWindowFlag,
    input wire logic serialPeriphFlag,
    input wire logic xtal_valid_irq,
    input wire logic [3:0] softIrq,
    input wire logic adcEocIrq,
    // Power and wake
    input wire logic missing_clock_detector,
    input wire logic wakeReset,
    // Outputs to core and peripherals
    output logic [1:0] bankSelect,
    output logic [4:0] bankBase,
    output logic baud_doubler,
    output logic [5:0] maskedRequests,
    output logic highPriorityPending,
    output logic lowPriorityPending,
    output logic cpuClockGate,
    output logic oscillatorOff,
    output logic mcdReset
);
    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [7:0] statusWord, next_statusWord;
    logic [7:0] irqEnable, next_irqEnable;
    logic [7:0] irqPriority, next_irqPriority;
    logic [7:0] powerControl, next_powerControl;
    core_status_pkg::power_state_t powerState, next_powerState;
    logic [31:0] mcdCount, next_mcdCount;
    logic [7:0] readData, next_readData;
    logic [5:0] next_masked;
    logic next_high, next_low, next_mcdReset;

    // ------------------------------------------------------------
    // Arithmetic flag computation
    // ------------------------------------------------------------
    logic [8:0] sum;
    logic [4:0] nibble;
    logic [15:0] product;
    logic carryIn, isAdd, isSub;

    always_comb
    begin
        carryIn = statusWord[`PSW_CARRY] & (aluOp != core_status_pkg::ALU_ADD);
        isAdd = (aluOp == core_status_pkg::ALU_ADD)
            | (aluOp == core_status_pkg::ALU_ADDC);
        isSub = (aluOp == core_status_pkg::ALU_SUBB);
        if (isSub)
        begin
            sum = {1'b0, aluOpA} - {1'b0, aluOpB} - {8'h00, carryIn};
            nibble = {1'b0, aluOpA[3:0]} - {1'b0, aluOpB[3:0]}
                - {4'h0, carryIn};
        end
        else
        begin
            sum = {1'b0, aluOpA} + {1'b0, aluOpB} + {8'h00, carryIn};
            nibble = {1'b0, aluOpA[3:0]} + {1'b0, aluOpB[3:0]}
                + {4'h0, carryIn};
        end
        product = aluOpA * aluOpB;
    end

    // ------------------------------------------------------------
    // Register next values
    // ------------------------------------------------------------
    always_comb
    begin
        next_statusWord = statusWord;
        next_irqEnable = irqEnable;
        next_irqPriority = irqPriority;
        next_powerControl = powerControl;
        if (sfrWrite)
        begin
            unique case (sfrAddr)
                `ADDR_STATUS_WORD:
                    next_statusWord = sfrWdata; // RULE3 RULE4
                `ADDR_IRQ_ENABLE_ONE:
                    next_irqEnable = sfrWdata & `IE_WRITE_MASK;
                `ADDR_IRQ_PRIORITY_TWO:
                    next_irqPriority = sfrWdata & `IP_WRITE_MASK;
                `ADDR_POWER_CONTROL:
                    next_powerControl = sfrWdata & `PC_WRITE_MASK;
                default:
                    next_powerControl = powerControl;
            endcase
        end
        // Hardware flag updates win over a software write in the same cycle
        if (aluValid && (isAdd || isSub))
        begin
            next_statusWord[`PSW_CARRY] = sum[8]; // RULE1
            next_statusWord[`PSW_AUX_CARRY] = nibble[4]; // RULE2
            next_statusWord[`PSW_OVERFLOW] =
                isAdd ? (aluOpA[7] == aluOpB[7]) && (sum[7] != aluOpA[7])
                      : (aluOpA[7] != aluOpB[7]) && (sum[7] != aluOpA[7]);
            // RULE6 RULE9
        end
        else if (aluValid && aluOp == core_status_pkg::ALU_MUL)
        begin
            next_statusWord[`PSW_CARRY] = 1'b0;
            next_statusWord[`PSW_OVERFLOW] = product > `BYTE_MAX; // RULE7
        end
        else if (aluValid && aluOp == core_status_pkg::ALU_DIV)
        begin
            next_statusWord[`PSW_CARRY] = 1'b0;
            next_statusWord[`PSW_OVERFLOW] = (aluOpB == 8'h00); // RULE8
        end
        next_statusWord[`PSW_PARITY] = ^accumulator; // RULE10
    end

    // ------------------------------------------------------------
    // Power mode sequencing
    // ------------------------------------------------------------
    always_comb
    begin
        next_powerState = powerState;
        next_mcdCount = 32'h0;
        next_mcdReset = 1'b0;
        unique case (powerState)
            core_status_pkg::PWR_RUN:
            begin
                if (sfrWrite && sfrAddr == `ADDR_POWER_CONTROL)
                begin
                    if (sfrWdata[`PC_STOP])
                        next_powerState = core_status_pkg::PWR_STOP; // RULE20
                    else if (sfrWdata[`PC_IDLE])
                        next_powerState = core_status_pkg::PWR_IDLE; // RULE21
                end
            end
            core_status_pkg::PWR_IDLE:
            begin
                // Any enabled request wakes the core from idle
                if (|maskedRequests || |softIrq || xtal_valid_irq
                    || adcEocIrq)
                    next_powerState = core_status_pkg::PWR_RUN;
            end
            core_status_pkg::PWR_STOP:
            begin
                // Only a reset can leave stop; the timer models the detector
                if (missing_clock_detector)
                begin
                    next_mcdCount = mcdCount + 32'h1;
                    if (mcdCount >= MCD_COUNT - 1)
                        next_mcdReset = 1'b1; // RULE17 RULE16
                end
            end
            default:
                next_powerState = core_status_pkg::PWR_RUN;
        endcase
    end

    // ------------------------------------------------------------
    // Interrupt gating, priority and read mux
    // ------------------------------------------------------------
    logic [7:0] srcHigh, srcPend;
    always_comb
    begin
        next_masked = {cmp1_rise_flag & irqEnable[`IE_CMP1_RISE],
                       cmp1_fall_flag & irqEnable[`IE_CMP1_FALL],
                       cmp0_rise_flag & irqEnable[`IE_CMP0_RISE],
                       cmp0_fall_flag & irqEnable[`IE_CMP0_FALL],
                       adcWindowFlag & irqEnable[`IE_ADC_WINDOW],
                       serialPeriphFlag & irqEnable[`IE_SERIAL]};
        // RULE11 RULE12
        srcPend = {xtal_valid_irq, softIrq, adcEocIrq, 2'b00};
        srcHigh = {irqPriority[`IP_XTAL],
                   irqPriority[`IP_SOFT_HI:`IP_SOFT_LO],
                   irqPriority[`IP_ADC_EOC], 2'b00};
        // RULE13 RULE14 RULE15
        next_high = |(srcPend & srcHigh); // RULE22
        next_low = !next_high && (|(srcPend & ~srcHigh) || |next_masked);
        unique case (sfrAddr)
            `ADDR_STATUS_WORD: next_readData = statusWord;
            `ADDR_IRQ_ENABLE_ONE: next_readData = irqEnable;
            `ADDR_IRQ_PRIORITY_TWO: next_readData = irqPriority;
            `ADDR_POWER_CONTROL: next_readData = powerControl; // RULE20 RULE21
            default: next_readData = 8'h00;
        endcase
        if (!sfrRead)
            next_readData = readData;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            statusWord <= `RESET_BYTE;
            irqEnable <= `RESET_BYTE;
            irqPriority <= `RESET_BYTE;
            powerControl <= `RESET_BYTE;
            powerState <= core_status_pkg::PWR_RUN; // RULE16
            mcdCount <= 32'h0;
            readData <= `RESET_BYTE;
            maskedRequests <= 6'h00;
            highPriorityPending <= 1'b0;
            lowPriorityPending <= 1'b0;
            mcdReset <= 1'b0;
        end
        else
        begin
            statusWord <= next_statusWord;
            irqEnable <= next_irqEnable;
            irqPriority <= next_irqPriority;
            powerControl <= next_powerControl;
            powerState <= wakeReset ? core_status_pkg::PWR_RUN
                                    : next_powerState;
            mcdCount <= next_mcdCount;
            readData <= next_readData;
            maskedRequests <= next_masked;
            highPriorityPending <= next_high;
            lowPriorityPending <= next_low;
            mcdReset <= next_mcdReset;
        end
    end

    // ------------------------------------------------------------
    // Flop-driven outputs
    // ------------------------------------------------------------
    always_comb
    begin
        sfrRdata = readData;
        bankSelect = statusWord[`PSW_BANK_HI:`PSW_BANK_LO]; // RULE4
        bankBase = {statusWord[`PSW_BANK_HI:`PSW_BANK_LO], 3'h0};
        baud_doubler = powerControl[`PC_BAUD]; // RULE19
        cpuClockGate = powerState != core_status_pkg::PWR_RUN; // RULE21
        oscillatorOff = powerState == core_status_pkg::PWR_STOP; // RULE20
    end
endmodule // core_status_irq_power_regs

// File: core/core_status_pkg.sv
// Types shared by the core status register block
package core_status_pkg;
    typedef enum logic [2:0] {
        ALU_NONE = 3'h0,
        ALU_ADD = 3'h1,
        ALU_ADDC = 3'h2,
        ALU_SUBB = 3'h3,
        ALU_MUL = 3'h4,
        ALU_DIV = 3'h5
    } alu_op_t;

    typedef enum logic [2:0] {
        PWR_RUN = 3'h1,
        PWR_IDLE = 3'h2,
        PWR_STOP = 3'h4
    } power_state_t;
endpackage

// File: core/core_status_regs_params.svh
// Offsets, field positions, reset values and timing for the core status regs
`ifndef CORE_STATUS_REGS_PARAMS_SVH
`define CORE_STATUS_REGS_PARAMS_SVH

`define ADDR_POWER_CONTROL 8'h87
`define ADDR_STATUS_WORD 8'hD0
`define ADDR_IRQ_ENABLE_ONE 8'hE6
`define ADDR_IRQ_PRIORITY_TWO 8'hF7

`define RESET_BYTE 8'h00

`define PSW_CARRY 7
`define PSW_AUX_CARRY 6
`define PSW_USER_ZERO 5
`define PSW_BANK_HI 4
`define PSW_BANK_LO 3
`define PSW_OVERFLOW 2
`define PSW_USER_ONE 1
`define PSW_PARITY 0

`define IE_WRITE_MASK 8'hF5
`define IE_CMP1_RISE 7
`define IE_CMP1_FALL 6
`define IE_CMP0_RISE 5
`define IE_CMP0_FALL 4
`define IE_ADC_WINDOW 2
`define IE_SERIAL 0

`define IP_WRITE_MASK 8'hBE
`define IP_XTAL 7
`define IP_SOFT_HI 5
`define IP_SOFT_LO 2
`define IP_ADC_EOC 1

`define PC_WRITE_MASK 8'hFC
`define PC_BAUD 7
`define PC_STOP 1
`define PC_IDLE 0

`define MCD_TIMEOUT_US 100
`define CLOCK_MHZ 25
`define MCD_CYCLES (`MCD_TIMEOUT_US * `CLOCK_MHZ)
`define NIBBLE_MAX 5'h0F
`define BYTE_MAX 16'h00FF

`endif

// File: testbench/core_status_chk.sv
// Port-level checks for the core status register block
module core_status_chk #(
    parameter int unsigned MCD_COUNT = 8
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic [7:0] sfrWdata,
    input wire logic sfrRead,
    input wire logic [7:0] sfrRdata,
    input wire logic aluValid,
    input wire core_status_pkg::alu_op_t aluOp,
    input wire logic [7:0] aluOpA,
    input wire logic [7:0] aluOpB,
    input wire logic [7:0] accumulator,
    input wire logic adcWindowFlag,
    input wire logic missing_clock_detector,
    input wire logic wakeReset,
    input wire logic [1:0] bankSelect,
    input wire logic [4:0] bankBase,
    input wire logic [5:0] maskedRequests,
    input wire logic highPriorityPending,
    input wire logic lowPriorityPending,
    input wire logic cpuClockGate,
    input wire logic oscillatorOff,
    input wire logic mcdReset
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    logic [15:0] stopCnt;
    logic [15:0] next_stopCnt;
    // Detector timer seen from outside; slack of three covers registering
    always_comb
    begin
        next_stopCnt = 16'h0000;
        if (oscillatorOff && missing_clock_detector)
            next_stopCnt = stopCnt + 16'h0001;
    end
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            stopCnt <= 16'h0000;
        else
            stopCnt <= next_stopCnt;
    end
    sequence s_mul_read;
        aluValid && aluOp == core_status_pkg::ALU_MUL ##1
        !aluValid && !sfrWrite ##1
        sfrRead && sfrAddr == 8'hD0 && !aluValid && !sfrWrite;
    endsequence
    a_bank_base_map: assert property (bankBase == {bankSelect, 3'b000})
        else $error("bank base wrong");
    a_mode_bits_zero: assert property (sfrRead && sfrAddr == 8'h87
        |=> sfrRdata[1:0] == 2'b00) else $error("mode bits read high");
    a_parity_read: assert property (sfrRead && sfrAddr == 8'hD0
        && $stable(accumulator) |=> sfrRdata[0] == ^$past(accumulator))
        else $error("parity wrong");
    a_stop_entry: assert property (sfrWrite && sfrAddr == 8'h87
        && sfrWdata[1] && !wakeReset |=> oscillatorOff && cpuClockGate)
        else $error("stop not entered");
    a_stop_hold: assert property (oscillatorOff && !wakeReset
        |=> oscillatorOff) else $error("stop left without reset");
    a_idle_gate: assert property (sfrWrite && sfrAddr == 8'h87
        && sfrWdata[1:0] == 2'b01 && !wakeReset
        |=> cpuClockGate && !oscillatorOff) else $error("idle not entered");
    a_prio_exclusive: assert property (!(highPriorityPending
        && lowPriorityPending)) else $error("both levels pending");
    a_window_gate: assert property (!adcWindowFlag
        |=> !maskedRequests[1]) else $error("window request leaked");
    a_mcd_timeout: assert property (stopCnt == 16'(MCD_COUNT + 3)
        |-> mcdReset) else $error("detector reset missing");
    a_mul_overflow: assert property (s_mul_read |=> !sfrRdata[7]
        && sfrRdata[2] == (16'($past(aluOpA, 3)) * $past(aluOpB, 3)
        > 16'h00FF)) else $error("multiply flags wrong");
endmodule // core_status_chk

bind core_status_irq_power_regs core_status_chk #(.MCD_COUNT(MCD_COUNT)) chk (
    .clock(clock), .rst(rst), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite),
    .sfrWdata(sfrWdata), .sfrRead(sfrRead), .sfrRdata(sfrRdata),
    .aluValid(aluValid), .aluOp(aluOp), .aluOpA(aluOpA), .aluOpB(aluOpB),
    .accumulator(accumulator), .adcWindowFlag(adcWindowFlag),
    .missing_clock_detector(missing_clock_detector), .wakeReset(wakeReset),
    .bankSelect(bankSelect), .bankBase(bankBase),
    .maskedRequests(maskedRequests), .cpuClockGate(cpuClockGate),
    .highPriorityPending(highPriorityPending), .mcdReset(mcdReset),
    .lowPriorityPending(lowPriorityPending), .oscillatorOff(oscillatorOff)
);

// File: testbench/exec_unit_model.sv
// Execution unit stand-in feeding arithmetic results to the block
module exec_unit_model (
    // Clock
    input wire logic clock,
    // Results towards the block
    output logic aluValid,
    output core_status_pkg::alu_op_t aluOp,
    output logic [7:0] aluOpA,
    output logic [7:0] aluOpB,
    output logic [7:0] accumulator
);
    timeunit 1ns;
    timeprecision 1ns;
    // No register moves are issued, so none follows a bank change
    // No analog blocks exist here, so none runs into stop
    initial
    begin
        aluValid = 1'b0;
        aluOp = core_status_pkg::ALU_NONE;
        aluOpA = 8'h00;
        aluOpB = 8'h00;
        accumulator = 8'h00;
    end
    task automatic run(input core_status_pkg::alu_op_t op,
                       input logic [7:0] a, input logic [7:0] b);
        @(posedge clock);
        aluValid <= 1'b1;
        aluOp <= op;
        aluOpA <= a;
        aluOpB <= b;
        @(posedge clock);
        aluValid <= 1'b0;
        aluOp <= core_status_pkg::ALU_NONE;
        // Stale operands change so nothing leans on held values
        aluOpA <= ~a;
        aluOpB <= ~b;
    endtask
    task automatic load(input logic [7:0] v);
        @(posedge clock);
        accumulator <= v;
    endtask
endmodule // exec_unit_model

// File: testbench/tb_core_status_irq_power_regs.sv
// Self-checking bench for the core status register block
module tb_core_status_irq_power_regs;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned MISSING_CLOCK_DETECTOR = 8;
    localparam logic [7:0] RA [5] = '{8'h87, 8'hD0, 8'hE6, 8'hF7, 8'h80};
    localparam logic [7:0] WA [3] = '{8'hD0, 8'hE6, 8'hF7};
    localparam logic [7:0] WE [3] = '{8'hFE, 8'hF5, 8'hBE};
    localparam logic [7:0] PE [6] = '{8'h80, 8'h3C, 8'h20, 8'h00, 8'h02, 8'h80};
    localparam logic [5:0] PS [6] = '{6'h20, 6'h20, 6'h10, 6'h01, 6'h01, 6'h21};
    localparam logic [7:0] PX [6] = '{8'h02, 8'h01, 8'h02, 8'h01, 8'h02, 8'h02};
    localparam logic [2:0] OC [7] = '{3'h1, 3'h2, 3'h1, 3'h3, 3'h4, 3'h5, 3'h5};
    localparam logic [7:0] AA [7] = '{8'hFF, 8'h00, 8'h7F, 8'h00, 8'h10, 8'h08, 8'h08};
    localparam logic [7:0] AB [7] = '{8'h01, 8'h00, 8'h01, 8'h01, 8'h10, 8'h00, 8'h02};
    localparam logic [7:0] AX [7] = '{8'hE2, 8'h22, 8'h66, 8'hE2, 8'h66, 8'h66, 8'h62};
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic sfrWrite = 1'b0;
    logic sfrRead = 1'b0;
    logic [7:0] sfrAddr = 8'h00;
    logic [7:0] sfrWdata = 8'h00;
    logic [5:0] flags = 6'h00;
    logic [5:0] prioSrc = 6'h00;
    logic mcdEnable = 1'b0;
    logic wakeReset = 1'b0;
    logic aluValid;
    core_status_pkg::alu_op_t aluOp;
    logic [7:0] aluOpA, aluOpB, accumulator, sfrRdata;
    logic [1:0] bankSelect;
    logic [4:0] bankBase;
    logic [5:0] maskedRequests;
    logic baudDoubler, highPend, lowPend, clockGate, oscOff, mcdReset;
    int badCount = 0;
    int numChecks = 0;
    int cycles = 0;
    core_status_irq_power_regs #(.MCD_COUNT(MISSING_CLOCK_DETECTOR)) dut (
        .clock(clock), .rst(rst), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite),
        .sfrWdata(sfrWdata), .sfrRead(sfrRead), .sfrRdata(sfrRdata),
        .aluValid(aluValid), .aluOp(aluOp), .aluOpA(aluOpA),
        .aluOpB(aluOpB), .accumulator(accumulator),
        .cmp1_rise_flag(flags[5]), .cmp1_fall_flag(flags[4]),
        .cmp0_rise_flag(flags[3]), .cmp0_fall_flag(flags[2]),
        .adcWindowFlag(flags[1]), .serialPeriphFlag(flags[0]),
        .xtal_valid_irq(prioSrc[5]), .softIrq(prioSrc[4:1]),
        .adcEocIrq(prioSrc[0]), .missing_clock_detector(mcdEnable),
        .wakeReset(wakeReset), .bankSelect(bankSelect), .bankBase(bankBase),
        .baud_doubler(baudDoubler), .maskedRequests(maskedRequests),
        .highPriorityPending(highPend), .lowPriorityPending(lowPend),
        .cpuClockGate(clockGate), .oscillatorOff(oscOff), .mcdReset(mcdReset)
    );
    exec_unit_model model (.clock(clock), .aluValid(aluValid), .aluOp(aluOp),
        .aluOpA(aluOpA), .aluOpB(aluOpB), .accumulator(accumulator));
    always #20 clock = ~clock;
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        numChecks++;
        if (got !== exp)
        begin
            badCount++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        sfrAddr <= a;
        sfrWdata <= d;
        sfrWrite <= 1'b1;
        @(posedge clock);
        sfrWrite <= 1'b0;
        sfrWdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] m,
                      input logic [7:0] exp);
        @(posedge clock);
        sfrAddr <= a;
        sfrRead <= 1'b1;
        @(posedge clock);
        sfrRead <= 1'b0;
        #1;
        chk("read data", exp, sfrRdata & m);
    endtask
    task automatic settle();
        repeat (2) @(posedge clock);
        #1;
    endtask
    task automatic wake();
        @(posedge clock);
        wakeReset <= 1'b1;
        @(posedge clock);
        wakeReset <= 1'b0;
        settle();
    endtask
    task automatic wrapUp();
        $display("checks %0d mismatches %0d", numChecks, badCount);
        if (badCount == 0 && numChecks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Ceiling sits well above the roughly 140 cycles the tests need
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            badCount++;
            wrapUp();
        end
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial
    begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        foreach (RA[i]) rd(RA[i], 8'hFF, 8'h00);
        foreach (WA[i])
        begin
            wr(WA[i], 8'hFF);
            rd(WA[i], 8'hFF, WE[i]);
        end
        chk("bank base", 8'h18, {3'h0, bankBase});
        wr(8'hD0, 8'h08);
        settle();
        chk("bank", 8'h21, {1'b0, bankBase, bankSelect});
        $display("register access done");
        wr(8'hE6, 8'hA0);
        flags <= 6'h3F;
        settle();
        chk("masked", 8'h28, {2'h0, maskedRequests});
        wr(8'hE6, 8'h54);
        settle();
        chk("masked", 8'h16, {2'h0, maskedRequests});
        flags <= 6'h00;
        $display("masking done");
        foreach (PE[i])
        begin
            wr(8'hF7, PE[i]);
            prioSrc <= PS[i];
            settle();
            chk("level", PX[i], {6'h00, highPend, lowPend});
        end
        prioSrc <= 6'h00;
        $display("priority done");
        wr(8'hD0, 8'h22);
        foreach (OC[i])
        begin
            model.run(core_status_pkg::alu_op_t'(OC[i]), AA[i], AB[i]);
            rd(8'hD0, 8'hE6, AX[i]);
        end
        model.load(8'h07);
        rd(8'hD0, 8'h01, 8'h01);
        model.load(8'h03);
        rd(8'hD0, 8'h01, 8'h00);
        $display("flags done");
        wr(8'h87, 8'h81);
        settle();
        chk("baud", 8'h01, {7'h00, baudDoubler});
        chk("gates", 8'h02, {6'h00, clockGate, oscOff});
        wake();
        chk("gates", 8'h00, {6'h00, clockGate, oscOff});
        rd(8'h87, 8'h83, 8'h80);
        // Idle is left by a pending request, not only by reset
        wr(8'h87, 8'h01);
        prioSrc <= 6'h01;
        settle();
        chk("gates", 8'h00, {6'h00, clockGate, oscOff});
        prioSrc <= 6'h00;
        mcdEnable <= 1'b1;
        wr(8'h87, 8'h02);
        settle();
        chk("gates", 8'h03, {6'h00, clockGate, oscOff});
        repeat (MISSING_CLOCK_DETECTOR + 4) @(posedge clock);
        #1;
        chk("detector", 8'h01, {7'h00, mcdReset});
        chk("gates", 8'h03, {6'h00, clockGate, oscOff});
        wake();
        mcdEnable <= 1'b0;
        chk("gates", 8'h00, {6'h00, clockGate, oscOff});
        rd(8'h87, 8'h03, 8'h00);
        $display("power done");
        wrapUp();
    end
endmodule // tb_core_status_irq_power_regs
